// >>> ict_consts.vh
// Constants shared by the instruction timing decoder files
`ifndef ICT_CONSTS_VH
`define ICT_CONSTS_VH

// ----------------------------------------
// Timing entry layout {cond, len[1:0], cyc[3:0]}
// ----------------------------------------
`define ICT_ENT_W       7
`define ICT_ENT_COND    6
`define ICT_ENT_LEN     5:4
`define ICT_ENT_CYC     3:0

// ----------------------------------------
// Entries: bytes, then cycles (not-taken count for conditionals)
// ----------------------------------------
`define ICT_T11         7'h11
`define ICT_T12         7'h12
`define ICT_T13         7'h13
`define ICT_T14         7'h14
`define ICT_T15         7'h15
`define ICT_T18         7'h18
`define ICT_T22         7'h22
`define ICT_T23         7'h23
`define ICT_T33         7'h33
`define ICT_T34         7'h34
`define ICT_C22         7'h62
`define ICT_C33         7'h73
`define ICT_C34         7'h74

// ----------------------------------------
// Opcodes and timing counts
// ----------------------------------------
`define ICT_OP_UNUSED   8'hA5
`define ICT_TAKEN_EXTRA 4'h1
`define ICT_CYC_ONE     4'h1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ICT_RST_ADDR    16'h0000
`define ICT_RST_OP      8'h00
`define ICT_RST_LEN     2'h1
`define ICT_RST_CYC     4'h1

`endif

// >>> ict_opcode_decode.v
// Opcode to byte length and clock cycle lookup
`include "ict_consts.vh"

module ict_opcode_decode
(
  // Opcode in
  input  wire [7:0] opcode,
  // Timing out
  output wire [1:0] op_len,
  output wire [3:0] op_cyc,
  output wire       op_cond
);

  // ----------------------------------------
  // Lookup
  // ----------------------------------------
  reg [`ICT_ENT_W-1:0] ent;

  always @*
  begin
    ent = `ICT_T11;
    if (opcode[3])
    begin
      case (opcode[7:4])
        4'h7, 4'h8, 4'hA: ent = `ICT_T22;
        4'hB:             ent = `ICT_C33;
        4'hD:             ent = `ICT_C22;
        default:          ent = `ICT_T11;
      endcase
    end
    else if (opcode[2:1] == 2'h3)
    begin
      case (opcode[7:4])
        4'h7, 4'h8, 4'hA: ent = `ICT_T22;
        4'hB:             ent = `ICT_C34;
        default:          ent = `ICT_T12;
      endcase
    end
    else
    begin
      case (opcode[2:0])
        3'h5:
        case (opcode[7:4])
          4'h7, 4'h8: ent = `ICT_T33;
          4'hB, 4'hD: ent = `ICT_C33;
          default:    ent = `ICT_T22;
        endcase
        3'h4:
        case (opcode[7:4])
          4'h8:       ent = `ICT_T18;
          4'hA:       ent = `ICT_T14;
          4'hB:       ent = `ICT_C33;
          4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9: ent = `ICT_T22;
          default:    ent = `ICT_T11;
        endcase
        3'h3:
        case (opcode[7:4])
          4'h4, 4'h5, 4'h6: ent = `ICT_T33;
          4'h7, 4'h8, 4'h9, 4'hE, 4'hF: ent = `ICT_T13;
          default:    ent = `ICT_T11;
        endcase
        3'h2:
        case (opcode[7:4])
          4'h0, 4'h1: ent = `ICT_T34;
          4'h2, 4'h3: ent = `ICT_T15;
          4'hE, 4'hF: ent = `ICT_T13;
          default:    ent = `ICT_T22;
        endcase
        3'h1:         ent = `ICT_T23;
        default:
        case (opcode[7:4])
          4'h0:       ent = `ICT_T11;
          4'h1, 4'h2, 4'h3: ent = `ICT_C33;
          4'h4, 4'h5, 4'h6, 4'h7: ent = `ICT_C22;
          4'h8:       ent = `ICT_T23;
          4'h9:       ent = `ICT_T33;
          4'hE, 4'hF: ent = `ICT_T13;
          default:    ent = `ICT_T22;
        endcase
      endcase
    end
    if (opcode == `ICT_OP_UNUSED)
      ent = `ICT_T11;
  end

  assign op_len  = ent[`ICT_ENT_LEN];
  assign op_cyc  = ent[`ICT_ENT_CYC];
  assign op_cond = ent[`ICT_ENT_COND];

endmodule // ict_opcode_decode

// >>> ict_rel_target.v
// Follow-on address and relative branch target
module ict_rel_target
(
  // Instruction in
  input  wire [15:0] insn_addr,
  input  wire [1:0]  insn_len,
  input  wire [7:0]  rel_offset,
  // Addresses out
  output wire [15:0] follow_addr,
  output wire [15:0] branch_target
);

  // ----------------------------------------
  // Address arithmetic
  // ----------------------------------------
  assign follow_addr   = insn_addr + {14'h0000, insn_len};
  assign branch_target = follow_addr + {{8{rel_offset[7]}}, rel_offset};

endmodule // ict_rel_target

// >>> ict_insn_timing.v
// Instruction issue sequencer with per-opcode length and cycle timing
`include "ict_consts.vh"

module ict_insn_timing
#(
  parameter STAT_W    = 16,
  parameter HIST_BINS = 8
)
(
  // Clock and reset
  input  wire                      sys_clk,
  input  wire                      rst_n,
  input  wire                      clk_en,
  // Fetch side
  input  wire                      fetch_valid,
  input  wire [7:0]                fetch_opcode,
  input  wire [15:0]               fetch_addr,
  input  wire [7:0]                fetch_rel,
  output wire                      fetch_ready,
  // Execute side
  input  wire                      branch_cond,
  // Current instruction
  output reg  [7:0]                insn_opcode,
  output reg  [1:0]                insn_len,
  output reg  [3:0]                insn_cycles,
  output reg                       insn_cond,
  output reg                       insn_taken,
  output reg  [15:0]               insn_target,
  output reg  [15:0]               next_fetch_addr,
  output reg  [3:0]                cycle_index,
  output wire                      insn_busy,
  output wire                      insn_done,
  // Statistics
  input  wire                      stats_clear,
  output reg  [STAT_W-1:0]         retired_count,
  output reg  [STAT_W-1:0]         cycle_count,
  output reg  [STAT_W-1:0]         taken_count,
  output wire [HIST_BINS*STAT_W-1:0] hist_flat
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_EXEC = 1'b1;

  // ----------------------------------------
  // Counter helper
  // ----------------------------------------
  function [STAT_W-1:0] ict_bump;
    input [STAT_W-1:0] cnt;
    input              clr;
    input              ev;
    begin
      if (clr)
        ict_bump = {{(STAT_W-1){1'b0}}, ev};
      else if (ev)
        ict_bump = cnt + {{(STAT_W-1){1'b0}}, 1'b1};
      else
        ict_bump = cnt;
    end
  endfunction

  // ----------------------------------------
  // Decode of the offered opcode
  // ----------------------------------------
  wire [1:0]  dec_len;
  wire [3:0]  dec_cyc;
  wire        dec_cond;
  wire [15:0] dec_follow;
  wire [15:0] dec_target;

  ict_opcode_decode u_decode
  (
    .opcode  (fetch_opcode),
    .op_len  (dec_len),
    .op_cyc  (dec_cyc),
    .op_cond (dec_cond)
  );

  ict_rel_target u_target
  (
    .insn_addr     (fetch_addr),
    .insn_len      (dec_len),
    .rel_offset    (fetch_rel),
    .follow_addr   (dec_follow),
    .branch_target (dec_target)
  );

  // ----------------------------------------
  // Issue handshake
  // ----------------------------------------
  reg        state;
  reg        next_state;
  reg  [3:0] remain;
  reg  [3:0] next_remain;

  wire       last_cycle;
  wire       accept;
  wire       acc_taken;
  wire [3:0] acc_total;

  assign last_cycle  = (state == ST_EXEC) && (remain == 4'h0);
  assign fetch_ready = clk_en && ((state == ST_IDLE) || last_cycle);
  assign accept      = fetch_valid && fetch_ready;
  assign acc_taken   = dec_cond && branch_cond;
  assign acc_total   = acc_taken ? (dec_cyc + `ICT_TAKEN_EXTRA) : dec_cyc;
  assign insn_busy   = (state == ST_EXEC);
  assign insn_done   = clk_en && last_cycle;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always @*
  begin
    next_state  = state;
    next_remain = remain;
    case (state)
      ST_IDLE:
      begin
        if (accept)
        begin
          next_state  = ST_EXEC;
          next_remain = acc_total - `ICT_CYC_ONE;
        end
      end
      ST_EXEC:
      begin
        if (remain != 4'h0)
          next_remain = remain - `ICT_CYC_ONE;
        else if (accept)
          next_remain = acc_total - `ICT_CYC_ONE;
        else
          next_state = ST_IDLE;
      end
      default:
      begin
        next_state  = ST_IDLE;
        next_remain = 4'h0;
      end
    endcase
  end

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state  <= ST_IDLE;
      remain <= 4'h0;
    end
    else if (clk_en)
    begin
      state  <= next_state;
      remain <= next_remain;
    end
  end

  // ----------------------------------------
  // Current instruction registers
  // ----------------------------------------
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      insn_opcode     <= `ICT_RST_OP;
      insn_len        <= `ICT_RST_LEN;
      insn_cycles     <= `ICT_RST_CYC;
      insn_cond       <= 1'b0;
      insn_taken      <= 1'b0;
      insn_target     <= `ICT_RST_ADDR;
      next_fetch_addr <= `ICT_RST_ADDR;
    end
    else if (clk_en && accept)
    begin
      insn_opcode     <= fetch_opcode;
      insn_len        <= dec_len;
      insn_cycles     <= acc_total;
      insn_cond       <= dec_cond;
      insn_taken      <= acc_taken;
      insn_target     <= dec_target;
      next_fetch_addr <= acc_taken ? dec_target : dec_follow;
    end
  end

  // ----------------------------------------
  // Elapsed clock within the instruction
  // ----------------------------------------
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      cycle_index <= 4'h0;
    else if (clk_en)
    begin
      if (accept)
        cycle_index <= 4'h0;
      else if (state == ST_EXEC)
        cycle_index <= cycle_index + `ICT_CYC_ONE;
    end
  end

  // ----------------------------------------
  // Statistics counters
  // ----------------------------------------
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      retired_count <= {STAT_W{1'b0}};
      cycle_count   <= {STAT_W{1'b0}};
      taken_count   <= {STAT_W{1'b0}};
    end
    else if (clk_en)
    begin
      retired_count <= ict_bump(retired_count, stats_clear, last_cycle);
      cycle_count   <= ict_bump(cycle_count, stats_clear, insn_busy);
      taken_count   <= ict_bump(taken_count, stats_clear, accept && acc_taken);
    end
  end

  // ----------------------------------------
  // Histogram of issued cycle counts
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < HIST_BINS; g = g + 1)
    begin : g_bin
      localparam [3:0] BIN_CYC = g + 1;
      reg [STAT_W-1:0] bin;
      always @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
          bin <= {STAT_W{1'b0}};
        else if (clk_en)
          bin <= ict_bump(bin, stats_clear, accept && (acc_total == BIN_CYC));
      end
      assign hist_flat[g*STAT_W +: STAT_W] = bin;
    end
  endgenerate

endmodule // ict_insn_timing

// >>> ict_insn_timing_sva.sv
// Timing checker for the instruction issue sequencer
module ict_insn_timing_sva
(
  // Clock and reset
  input wire        sys_clk,
  input wire        rst_n,
  input wire        clk_en,
  // Fetch side and execute side
  input wire        fetch_valid,
  input wire [7:0]  fetch_opcode,
  input wire [15:0] fetch_addr,
  input wire [7:0]  fetch_rel,
  input wire        fetch_ready,
  input wire        branch_cond,
  // Current instruction
  input wire [1:0]  insn_len,
  input wire [3:0]  insn_cycles,
  input wire        insn_taken,
  input wire [15:0] insn_target,
  input wire [15:0] next_fetch_addr,
  input wire [3:0]  cycle_index,
  input wire        insn_busy,
  input wire        insn_done
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire acc = fetch_valid & fetch_ready;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_done_ready: assert property (insn_done && clk_en |-> fetch_ready)
    else $error("ready low in last cycle");
  a_en_refuse: assert property (!clk_en |-> !fetch_ready)
    else $error("ready high while disabled");
  a_done_index: assert property (insn_done |-> cycle_index == insn_cycles - 4'h1)
    else $error("done away from last cycle");
  a_start_busy: assert property (acc |=> insn_busy && cycle_index == 4'h0)
    else $error("no busy start after accept");
  a_div_eight: assert property (acc && fetch_opcode == 8'h84 |=> insn_len == 2'h1 && insn_cycles == 4'h8)
    else $error("divide timing wrong");
  a_mul_four: assert property (acc && fetch_opcode == 8'hA4 |=> insn_len == 2'h1 && insn_cycles == 4'h4)
    else $error("multiply timing wrong");
  a_unused_nop: assert property (acc && fetch_opcode == 8'hA5 |=> insn_len == 2'h1 && insn_cycles == 4'h1)
    else $error("unused opcode not a no-op");
  a_taken_extra: assert property (acc && fetch_opcode == 8'h40 |=> insn_cycles == ($past(branch_cond) ? 4'h3 : 4'h2))
    else $error("branch cycles wrong");
  a_rel_target: assert property (acc |=> insn_target == $past(fetch_addr) + {14'h0, insn_len}
    + {{8{$past(fetch_rel[7])}}, $past(fetch_rel)})
    else $error("relative target wrong");
  a_next_fetch: assert property (acc |=> next_fetch_addr ==
    (insn_taken ? insn_target : $past(fetch_addr) + {14'h0, insn_len}))
    else $error("next fetch address wrong");
endmodule // ict_insn_timing_sva

bind ict_insn_timing ict_insn_timing_sva i_sva (.sys_clk, .rst_n, .clk_en, .fetch_valid, .fetch_opcode,
  .fetch_addr, .fetch_rel, .fetch_ready, .branch_cond, .insn_len, .insn_cycles, .insn_taken,
  .insn_target, .next_fetch_addr, .cycle_index, .insn_busy, .insn_done);

// >>> ict_insn_timing_tb_top.sv
// Testbench for the instruction issue sequencer
module ict_insn_timing_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 0, rst_n = 0, clk_en = 1, fetch_valid = 0, branch_cond = 0, stats_clear = 0;
  logic [7:0]  fetch_opcode = 8'h00, fetch_rel = 8'h00, insn_opcode;
  logic [15:0] fetch_addr = 16'h1000, insn_target, next_fetch_addr, retired_count, cycle_count, taken_count;
  logic [127:0] hist_flat;
  logic [1:0]  insn_len;
  logic [3:0]  insn_cycles, cycle_index;
  logic        fetch_ready, insn_cond, insn_taken, insn_busy, insn_done;
  int          n_fail = 0, samples_checked = 0, n;

  ict_insn_timing i_dut (.sys_clk, .rst_n, .clk_en, .fetch_valid, .fetch_opcode, .fetch_addr, .fetch_rel,
    .fetch_ready, .branch_cond, .insn_opcode, .insn_len, .insn_cycles, .insn_cond, .insn_taken,
    .insn_target, .next_fetch_addr, .cycle_index, .insn_busy, .insn_done, .stats_clear,
    .retired_count, .cycle_count, .taken_count, .hist_flat);

  initial forever #10 sys_clk = ~sys_clk;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask

  // Offer one opcode, hold until taken, then count clocks up to done
  task automatic run_op(input logic [7:0] op, input logic [7:0] rel, input logic cnd, input logic stall);
    int w;
    w = 0;
    fetch_valid = 1;
    fetch_opcode = op;
    fetch_rel = rel;
    branch_cond = cnd;
    while (fetch_ready !== 1'b1 && w < 50)
    begin
      @(posedge sys_clk); #1 w++;
    end
    @(posedge sys_clk); #1 fetch_valid = 0;
    if (stall)
    begin
      clk_en = 0;
      repeat (3) @(posedge sys_clk);
      #1 check("frozen index", 16'h0, {12'h0, cycle_index});
      check("ready disabled", 16'h0, {15'h0, fetch_ready});
      clk_en = 1;
    end
    n = 1;
    while (insn_done !== 1'b1 && n < 20)
    begin
      @(posedge sys_clk); #1 n++;
    end
  endtask

  task automatic chk_op(input logic [7:0] op, input logic [1:0] len, input logic [3:0] cyc);
    run_op(op, 8'h00, 1'b0, 1'b0);
    check("len", {14'h0, len}, {14'h0, insn_len});
    check("cycles", {12'h0, cyc}, {12'h0, insn_cycles});
    check("done after", {12'h0, cyc}, n[15:0]);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_table;
    chk_op(8'h28, 2'h1, 4'h1); chk_op(8'h35, 2'h2, 4'h2);
    chk_op(8'h96, 2'h1, 4'h2); chk_op(8'h24, 2'h2, 4'h2);
    chk_op(8'hA4, 2'h1, 4'h4); chk_op(8'h84, 2'h1, 4'h8);
    chk_op(8'hA3, 2'h1, 4'h1); chk_op(8'h04, 2'h1, 4'h1);
    chk_op(8'h15, 2'h2, 4'h2); chk_op(8'h16, 2'h1, 4'h2);
    chk_op(8'h53, 2'h3, 4'h3); chk_op(8'h63, 2'h3, 4'h3);
    chk_op(8'h62, 2'h2, 4'h2); chk_op(8'h48, 2'h1, 4'h1);
    chk_op(8'hE4, 2'h1, 4'h1); chk_op(8'h33, 2'h1, 4'h1); chk_op(8'hC4, 2'h1, 4'h1);
    chk_op(8'hF8, 2'h1, 4'h1); chk_op(8'hA8, 2'h2, 4'h2); chk_op(8'h78, 2'h2, 4'h2);
    chk_op(8'h85, 2'h3, 4'h3); chk_op(8'h75, 2'h3, 4'h3);
    chk_op(8'hF6, 2'h1, 4'h2); chk_op(8'hA6, 2'h2, 4'h2); chk_op(8'h76, 2'h2, 4'h2);
    chk_op(8'h90, 2'h3, 4'h3); chk_op(8'h93, 2'h1, 4'h3); chk_op(8'h83, 2'h1, 4'h3);
    chk_op(8'hE2, 2'h1, 4'h3); chk_op(8'hF0, 2'h1, 4'h3);
    chk_op(8'hC0, 2'h2, 4'h2); chk_op(8'hD0, 2'h2, 4'h2);
    chk_op(8'hC8, 2'h1, 4'h1); chk_op(8'hC5, 2'h2, 4'h2); chk_op(8'hD6, 2'h1, 4'h2);
    chk_op(8'hC3, 2'h1, 4'h1); chk_op(8'hD3, 2'h1, 4'h1); chk_op(8'hB2, 2'h2, 4'h2);
    chk_op(8'hA5, 2'h1, 4'h1);
  endtask

  task automatic test_branch;
    run_op(8'h40, 8'hFE, 1'b1, 1'b0);
    check("taken cycles", 16'h3, n[15:0]);
    check("taken target", 16'h1000, next_fetch_addr);
    check("cond flag", 16'h1, {15'h0, insn_cond});
    check("taken flag", 16'h1, {15'h0, insn_taken});
    check("opcode", 16'h40, {8'h0, insn_opcode});
    run_op(8'h40, 8'h10, 1'b0, 1'b0);
    check("fall cycles", 16'h2, n[15:0]);
    check("target", 16'h1012, insn_target);
    check("fall next", 16'h1002, next_fetch_addr);
  endtask

  task automatic test_stall_stats;
    @(posedge sys_clk); #1 stats_clear = 1;
    @(posedge sys_clk); #1 stats_clear = 0;
    run_op(8'h84, 8'h00, 1'b0, 1'b1);
    check("stalled divide", 16'h8, n[15:0]);
    @(posedge sys_clk); #1 check("retired", 16'h1, retired_count);
    check("busy cycles", 16'h8, cycle_count);
    check("taken count", 16'h0, taken_count);
    check("eight bin", 16'h1, hist_flat[7*16 +: 16]);
    check("one bin", 16'h0, hist_flat[15:0]);
    check("idle busy", 16'h0, {15'h0, insn_busy});
    check("idle ready", 16'h1, {15'h0, fetch_ready});
  endtask

  initial
  begin
    repeat (5) @(posedge sys_clk);
    #1 rst_n = 1;
    test_table;
    test_branch;
    test_stall_stats;
    wrap_up;
  end

  initial
  begin
    #100000;
    n_fail++;
    wrap_up;
  end
endmodule // ict_insn_timing_tb_top
